// *** pkg/ipsr_pkg.sv ***
/*
 Package for the image packet sizing register bank: offsets, field
 layouts, reset values and fixed limits.
 Assumes a 32-bit AXI4-Lite register bus with byte addressing.
*/
package ipsr_pkg;
    // Register byte offsets
    localparam logic [7:0] IPSR_OFF_ROI_SIZE = 8'h0c;
    localparam logic [7:0] IPSR_OFF_ENC_SEL = 8'h10;
    localparam logic [7:0] IPSR_OFF_ENC_CAP = 8'h14;
    localparam logic [7:0] IPSR_OFF_PIX_CNT = 8'h34;
    localparam logic [7:0] IPSR_OFF_BYTES_HI = 8'h38;
    localparam logic [7:0] IPSR_OFF_BYTES_LO = 8'h3c;
    localparam logic [7:0] IPSR_OFF_PKT_LIM = 8'h40;
    localparam logic [7:0] IPSR_OFF_PKT_SET = 8'h44;
    localparam logic [7:0] IPSR_OFF_EXTRA = 8'h60;
    // Field positions
    localparam int IPSR_LO_LSB = 0;
    localparam int IPSR_HI_LSB = 16;
    // Fixed packet limits
    localparam logic [15:0] IPSR_PKT_UNIT = 16'h0004;
    localparam logic [15:0] IPSR_PKT_MAX = 16'h1000;
    // Most packets one frame may take
    localparam int IPSR_MAX_PKTS = 4095;
    // Reset values
    localparam logic [15:0] IPSR_RST_WIDTH = 16'h0570;
    localparam logic [15:0] IPSR_RST_HEIGHT = 16'h0410;
    localparam logic [7:0] IPSR_RST_ENC = 8'h00;
    localparam logic [15:0] IPSR_RST_PKT = 16'h1000;
    localparam logic [31:0] IPSR_RST_EXTRA = 32'h0000_0000;
    // Supported encodings, bit n set means identifier n is supported
    localparam logic [31:0] IPSR_ENC_CAP = 32'h0000_0021;
    // AXI responses
    localparam logic [1:0] IPSR_RESP_OKAY = 2'b00;
    localparam logic [1:0] IPSR_RESP_SLVERR = 2'b10;
endpackage

// *** hdl/ipsr_regs.sv ***
/*
 Image packet sizing register bank with an AXI4-Lite slave: region size,
 pixel encoding, feature byte and packet size settings, and the frame
 figures derived from them (pixel count, byte total and the recommended
 packet size), plus the fixed packet limits.
 Assumes one clock, a synchronous active-low reset and a master with at
 most one write and one read under way at a time. Only the low eight
 address bits are decoded; word offsets are byte addresses.
 Writes to read-only offsets answer OKAY and are dropped; unknown offsets
 answer SLVERR. Write strobes merge byte lanes onto the current word.
 Derived figures lag a setting by one cycle, so a read issued after the
 write response always sees them settled. The recommended size is the
 next unit multiple above the whole part of the byte total over the packet count, capped at the packet ceiling.
 Packet size writes are not range-checked here; software keeps them legal.
*/
`timescale 1ns/1ps
module ipsr_regs #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [15:0] packet_payload_len
);
    import ipsr_pkg::*;

    typedef struct packed {
        // Write address and data captured from the bus
        logic aw_hold;
        logic [ADDR_W-1:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        // Responses held until the master takes them
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        // Settings written by software
        logic [15:0] roi_width;
        logic [15:0] roi_height;
        logic [7:0] enc_sel;
        logic [31:0] extra_bytes;
        logic [15:0] pkt_size;
        // Figures derived from the settings
        logic [31:0] pix_cnt;
        logic [63:0] byte_total;
        logic [15:0] rec_pkt;
        logic [15:0] pay_len;
    } ipsr_state_t;

    ipsr_state_t st_r;
    ipsr_state_t st_nxt;

    // Frame arithmetic, one step of the byte count each
    logic [31:0] pix_calc;
    logic [3:0] half_bytes;
    logic [63:0] half_calc;
    logic [63:0] bytes_calc;
    logic [63:0] rounded_calc;
    logic [63:0] padded_calc;
    logic [63:0] pkt_floor;
    logic [63:0] rec_wide;
    logic over_limit;
    logic [15:0] rec_calc;

    // Register bus helpers
    logic [7:0] rd_sel;
    logic [7:0] wr_sel;
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_go;
    logic [31:0] wr_merge;
    logic [31:0] wr_old;

    // Bytes per pixel times two, so half-byte formats stay exact
    function automatic logic [3:0] ipsr_half_bytes(input logic [7:0] enc);
        case (enc)
            8'h00: ipsr_half_bytes = 4'h2;
            8'h01: ipsr_half_bytes = 4'h3;
            8'h02: ipsr_half_bytes = 4'h4;
            8'h03: ipsr_half_bytes = 4'h6;
            8'h04: ipsr_half_bytes = 4'h6;
            8'h05: ipsr_half_bytes = 4'h4;
            8'h06: ipsr_half_bytes = 4'hc;
            8'h07: ipsr_half_bytes = 4'h4;
            8'h08: ipsr_half_bytes = 4'hc;
            8'h09: ipsr_half_bytes = 4'h2;
            8'h0a: ipsr_half_bytes = 4'h4;
            // Unknown identifiers count as one byte
            default: ipsr_half_bytes = 4'h2;
        endcase
    endfunction

    // Pixel count from the region size
    always_comb begin
        pix_calc = 32'(st_r.roi_width) * 32'(st_r.roi_height);
    end

    // Payload bytes; an odd half byte rounds up
    always_comb begin
        half_bytes = ipsr_half_bytes(st_r.enc_sel);
        half_calc = 64'(pix_calc) * 64'(half_bytes);
        bytes_calc = (half_calc + 64'h1) >> 1;
    end

    // Pad payload up to a whole unit, then add feature bytes
    always_comb begin
        rounded_calc = (bytes_calc + 64'h3) & ~64'h3;
        padded_calc = rounded_calc + 64'(st_r.extra_bytes);
    end

    // Next unit multiple above the whole part of padded bytes over the packet count
    // Coarse proxy for the top frame rate: fewest bytes per packet that fit
    always_comb begin
        pkt_floor = padded_calc / 64'(IPSR_MAX_PKTS);
        rec_wide = (pkt_floor + 64'd4) & ~64'h3;
        over_limit = padded_calc >= 64'(IPSR_PKT_MAX) * 64'(IPSR_MAX_PKTS);
        if (over_limit) begin
            rec_calc = IPSR_PKT_MAX; // At or past the ceiling times the packet count; report the ceiling
        end else begin
            rec_calc = 16'(rec_wide);
        end
    end

    // Only the low byte of an address selects a register
    assign rd_sel = 8'(s_axi_araddr);
    assign wr_sel = 8'(st_r.aw_addr);

    // Read mux for the register map
    always_comb begin
        rd_hit = 1'b1;
        case (rd_sel)
            // Settings read back as written
            IPSR_OFF_ROI_SIZE: begin
                rd_word = {st_r.roi_height, st_r.roi_width};
            end
            IPSR_OFF_ENC_SEL: begin
                rd_word = {24'h000000, st_r.enc_sel};
            end
            IPSR_OFF_EXTRA: begin
                rd_word = st_r.extra_bytes;
            end
            // Fixed and derived inquiry words, then the recommended size paired with the packet size setting
            IPSR_OFF_ENC_CAP: begin
                rd_word = IPSR_ENC_CAP;
            end
            IPSR_OFF_PIX_CNT: begin
                rd_word = st_r.pix_cnt;
            end
            IPSR_OFF_BYTES_HI: begin
                rd_word = st_r.byte_total[63:32];
            end
            IPSR_OFF_BYTES_LO: begin
                rd_word = st_r.byte_total[31:0];
            end
            IPSR_OFF_PKT_LIM: begin
                rd_word = {IPSR_PKT_MAX, IPSR_PKT_UNIT};
            end
            IPSR_OFF_PKT_SET: begin
                rd_word = {st_r.rec_pkt, st_r.pkt_size};
            end
            // Anything else answers an error with zeros
            default: begin
                rd_word = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Old word of the addressed setting, so unstrobed lanes keep their value
    always_comb begin
        case (wr_sel)
            IPSR_OFF_ROI_SIZE: wr_old = {st_r.roi_height, st_r.roi_width};
            IPSR_OFF_ENC_SEL: wr_old = {24'h000000, st_r.enc_sel};
            IPSR_OFF_PKT_SET: wr_old = {16'h0000, st_r.pkt_size};
            IPSR_OFF_EXTRA: wr_old = st_r.extra_bytes;
            // Read-only offsets merge against zero
            default: wr_old = 32'h0000_0000;
        endcase
    end

    // One merge lane per byte strobe
    for (genvar g = 0; g < 4; g++) begin : g_lane
        assign wr_merge[g*8 +: 8] = st_r.w_strb[g] ? st_r.w_data[g*8 +: 8] : wr_old[g*8 +: 8];
    end

    // A write commits once address and data are held and no response waits
    assign wr_go = st_r.aw_hold && st_r.w_hold && !st_r.bvalid;

    // Next state of bus handshakes, settings and derived values
    always_comb begin
        st_nxt = st_r;

        // Capture the write address
        if (s_axi_awvalid && !st_r.aw_hold) begin
            st_nxt.aw_hold = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end

        // Capture the write data and its strobes
        if (s_axi_wvalid && !st_r.w_hold) begin
            st_nxt.w_hold = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end

        // Write response taken by the master
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // Commit the write and answer it
        if (wr_go) begin
            st_nxt.aw_hold = 1'b0;
            st_nxt.w_hold = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = IPSR_RESP_OKAY;
            case (wr_sel)
                IPSR_OFF_ROI_SIZE: begin
                    st_nxt.roi_width = wr_merge[IPSR_LO_LSB +: 16];
                    st_nxt.roi_height = wr_merge[IPSR_HI_LSB +: 16];
                end
                IPSR_OFF_ENC_SEL: begin
                    st_nxt.enc_sel = wr_merge[7:0];
                end
                IPSR_OFF_PKT_SET: begin
                    st_nxt.pkt_size = wr_merge[IPSR_LO_LSB +: 16];
                end
                IPSR_OFF_EXTRA: begin
                    st_nxt.extra_bytes = wr_merge;
                end
                // Inquiry offsets accept and drop the data
                IPSR_OFF_ENC_CAP, IPSR_OFF_PIX_CNT, IPSR_OFF_BYTES_HI,
                IPSR_OFF_BYTES_LO, IPSR_OFF_PKT_LIM: begin
                    st_nxt.bresp = IPSR_RESP_OKAY;
                end
                default: begin
                    st_nxt.bresp = IPSR_RESP_SLVERR;
                end
            endcase
        end

        // Read data taken by the master
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end

        // Capture a read address with its data and response
        if (s_axi_arvalid && !st_r.rvalid) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd_word;
            st_nxt.rresp = rd_hit ? IPSR_RESP_OKAY : IPSR_RESP_SLVERR;
        end

        // Derived values follow settings one cycle later
        st_nxt.pix_cnt = pix_calc;
        st_nxt.byte_total = padded_calc;
        st_nxt.rec_pkt = rec_calc;
        // Packet length takes the setting a cycle after it lands
        st_nxt.pay_len = st_r.pkt_size;
    end

    // State register with reset values
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Bus side idle, nothing held
            st_r.aw_hold <= 1'b0;
            st_r.aw_addr <= '0;
            st_r.w_hold <= 1'b0;
            st_r.w_data <= 32'h0000_0000;
            st_r.w_strb <= 4'h0;
            st_r.bvalid <= 1'b0;
            st_r.bresp <= IPSR_RESP_OKAY;
            st_r.rvalid <= 1'b0;
            st_r.rresp <= IPSR_RESP_OKAY;
            st_r.rdata <= 32'h0000_0000;
            // Settings at their power-up values
            st_r.roi_width <= IPSR_RST_WIDTH;
            st_r.roi_height <= IPSR_RST_HEIGHT;
            st_r.enc_sel <= IPSR_RST_ENC;
            st_r.extra_bytes <= IPSR_RST_EXTRA;
            st_r.pkt_size <= IPSR_RST_PKT;
            // Derived figures valid from the first edge after release
            st_r.pix_cnt <= 32'h0000_0000;
            st_r.byte_total <= 64'h0;
            st_r.rec_pkt <= 16'h0000;
            st_r.pay_len <= IPSR_RST_PKT;
        end else begin
            // Otherwise take the computed next state
            st_r <= st_nxt;
        end
    end

    // Write channel outputs straight from the state register
    assign s_axi_awready = !st_r.aw_hold;
    assign s_axi_wready = !st_r.w_hold;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;

    // Read channel outputs straight from the state register
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;

    // Packet length in force for transmission
    assign packet_payload_len = st_r.pay_len;
endmodule // ipsr_regs

// *** dv/ipsr_regs_properties.sv ***
/* Bus and field checks for the packet sizing bank.
 Sees only the top ports; bound from the bench top file. */
`timescale 1ns/1ps
module ipsr_regs_properties import ipsr_pkg::*; #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] packet_payload_len
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Handshake steps
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered");
    a_limits_read: assert property (s_rd_taken ##0 s_axi_araddr[7:0] == IPSR_OFF_PKT_LIM
        |=> s_axi_rdata == {IPSR_PKT_MAX, IPSR_PKT_UNIT})
        else $error("bad packet limits");
    a_cap_read: assert property (s_rd_taken ##0 s_axi_araddr[7:0] == IPSR_OFF_ENC_CAP
        |=> s_axi_rdata == IPSR_ENC_CAP)
        else $error("bad capability word");
    a_unmapped_read: assert property (s_rd_taken ##0 s_axi_araddr[7:0] == 8'h20
        |=> s_axi_rresp == IPSR_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read accepted");
    a_len_cause: assert property ($changed(packet_payload_len) |-> !$past(s_axi_awready, 2))
        else $error("length moved without a write");
endmodule // ipsr_regs_properties

// *** dv/testbench.sv ***
/* Self-checking bench for the packet sizing bank.
 Drives the AXI4-Lite port directly; model computes expected values. */
`timescale 1ns/1ps
module testbench;
    import ipsr_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0;
    logic rrdy = 1'b0, awr, wr, bv, arr, rv;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [3:0] ws = 4'hf;
    logic [7:0] ro_offs[5] = '{IPSR_OFF_ENC_CAP, IPSR_OFF_PIX_CNT, IPSR_OFF_BYTES_HI,
        IPSR_OFF_BYTES_LO, IPSR_OFF_PKT_LIM};
    logic [31:0] wd = 32'h0, rd;
    logic [1:0] br, rr;
    logic [15:0] plen;
    int num_errors = 0, samples_checked = 0;
    longint w, h, enc, extra, pkt, tot, rec;
    ipsr_regs u_ipsr_regs (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
        .packet_payload_len(plen));
    // Clock
    initial begin
        forever #25 aclk = ~aclk;
    end
    task conclude;
        if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One write, address and data offered together
    task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw_ok, w_ok;
        @(posedge aclk);
        awa <= a; awv <= 1'b1; wd <= d; wv <= 1'b1; brdy <= 1'b1;
        aw_ok = 0; w_ok = 0;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awr) begin aw_ok = 1; awv <= 1'b0; end
            if (!w_ok && wr) begin w_ok = 1; wv <= 1'b0; end
        end
        do @(posedge aclk); while (!bv);
        brdy <= 1'b0;
        check(32'(br), 32'(er));
    endtask
    // One read and compare
    task axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        ara <= a; arv <= 1'b1; rrdy <= 1'b1;
        do @(posedge aclk); while (!arr);
        arv <= 1'b0;
        do @(posedge aclk); while (!rv);
        rrdy <= 1'b0;
        check(rd, e);
        check(32'(rr), 32'(er));
    endtask
    // Bytes per pixel, in halves
    function automatic longint halves(longint e);
        case (e)
            1: return 3;
            2, 5, 7, 10: return 4;
            3, 4: return 6;
            6, 8: return 12;
            default: return 2;
        endcase
    endfunction
    // Model result against every derived register
    task predict;
        tot = ((w * h * halves(enc) + 1) / 2 + 3) / 4 * 4 + extra;
        rec = (tot / IPSR_MAX_PKTS + 4) / 4 * 4;
        if (rec > 4096) rec = 4096;
    endtask
    task verify;
        predict;
        repeat (2) @(posedge aclk);
        axi_rd(IPSR_OFF_PIX_CNT, 32'(w * h), IPSR_RESP_OKAY);
        axi_rd(IPSR_OFF_BYTES_HI, 32'(tot >> 32), IPSR_RESP_OKAY);
        axi_rd(IPSR_OFF_BYTES_LO, 32'(tot), IPSR_RESP_OKAY);
        axi_rd(IPSR_OFF_PKT_LIM, {IPSR_PKT_MAX, IPSR_PKT_UNIT}, IPSR_RESP_OKAY);
        axi_rd(IPSR_OFF_PKT_SET, {16'(rec), 16'(pkt)}, IPSR_RESP_OKAY);
        axi_rd(IPSR_OFF_ENC_CAP, IPSR_ENC_CAP, IPSR_RESP_OKAY);
        check(32'(plen), 32'(pkt));
    endtask
    // Main sequence
    initial begin
        void'($urandom(39820));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        w = IPSR_RST_WIDTH; h = IPSR_RST_HEIGHT; enc = IPSR_RST_ENC; extra = 0; pkt = IPSR_RST_PKT;
        verify;
        foreach (ro_offs[i]) axi_wr(ro_offs[i], $urandom, IPSR_RESP_OKAY);
        axi_wr(8'h20, $urandom, IPSR_RESP_SLVERR);
        axi_rd(8'h20, 32'h0, IPSR_RESP_SLVERR);
        verify;
        for (int i = 0; i < 24; i++) begin
            w = $urandom_range(1, (i % 4 == 3) ? 65535 : 1600);
            h = $urandom_range(1, (i % 4 == 3) ? 65535 : 1600);
            enc = i % 12;
            extra = $urandom_range(0, 255);
            predict;
            pkt = $urandom_range(rec / 4, 1024) * 4;
            axi_wr(IPSR_OFF_ROI_SIZE, {16'(h), 16'(w)}, IPSR_RESP_OKAY);
            axi_wr(IPSR_OFF_ENC_SEL, 32'(enc), IPSR_RESP_OKAY);
            axi_wr(IPSR_OFF_EXTRA, 32'(extra), IPSR_RESP_OKAY);
            axi_wr(IPSR_OFF_PKT_SET, {16'($urandom), 16'(pkt)}, IPSR_RESP_OKAY);
            verify;
        end
        // Width lanes only: height must keep its value
        ws <= 4'h3;
        w = $urandom_range(1, 1600);
        axi_wr(IPSR_OFF_ROI_SIZE, {16'hffff, 16'(w)}, IPSR_RESP_OKAY);
        ws <= 4'hf;
        verify;
        conclude;
    end
    // Hang guard
    initial begin
        #1_000_000;
        num_errors++;
        conclude;
    end
endmodule // testbench
bind ipsr_regs ipsr_regs_properties #(.ADDR_W(ADDR_W)) u_props (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .packet_payload_len);
